// ---- logic/fpklc_pkg.sv ----
// constants, types and register map of the front panel key and lamp control
package fpklc_pkg;
  // clock and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // keys
  localparam int NUM_KEYS = 8;
  localparam int K_RUN = 0;
  localparam int K_RESET = 1;
  localparam int K_CONFIRM = 2;
  localparam int K_VIEW = 3;
  localparam int K_UP = 4;
  localparam int K_DOWN = 5;
  localparam int K_PATTERN = 6;
  localparam int K_MODE = 7;
  // hold counter width in bits, then debounce, hold and repeat times in ms
  localparam int HOLD_W = 13;
  localparam int DEBOUNCE_MS = 20;
  localparam int RUN_HOLD_MS = 2000;
  localparam int MENU_HOLD_MS = 3000;
  localparam int REPEAT_DELAY_MS = 500;
  localparam int REPEAT_SLOW_MS = 200;
  localparam int REPEAT_MID_MS = 100;
  localparam int REPEAT_FAST_MS = 40;
  localparam int REPEAT_MID_AT_MS = 1500;
  localparam int REPEAT_FAST_AT_MS = 3000;
  // contact inputs
  localparam int NUM_CONTACTS = 7;
  localparam int CONTACT_STABLE_SAMPLES = 3;
  localparam int SAMPLE_MS = 100;
  localparam int C_RUN = 0;
  localparam int C_RESET = 1;
  localparam logic [7:0] CONTACT_ENABLE_CODE = 8'h02;
  // views and menu
  localparam int OPER_VIEWS = 4;
  localparam int NUM_PATTERNS = 30;
  localparam logic [3:0] MENU_ENTRIES = 4'hF;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EVENT = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_ENABLE_LSB = 0;
  localparam int CTRL_SWITCHED_BIT = 8;
  localparam int ST_VIEW_LSB = 0;
  localparam int ST_OPER_LSB = 4;
  localparam int ST_PATTERN_LSB = 8;
  localparam int ST_CONTACT_LSB = 16;
  localparam int ST_MENU_LSB = 24;
  localparam int EV_RUN = 0;
  localparam int EV_STOP = 1;
  localparam int EV_MENU = 2;
  localparam int EV_COMMIT = 3;
  localparam int EV_PATTERN = 4;
  localparam int EV_CONTACT = 5;
  localparam int NUM_EVENTS = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    VIEW_OPER = 3'b000,
    VIEW_MENU_TOP = 3'b001,
    VIEW_MENU_SUB = 3'b010,
    VIEW_PARAM = 3'b011,
    VIEW_MODE_SEL = 3'b100
  } fpklc_view_t;

  typedef struct packed {
    logic trend_rise;
    logic trend_const;
    logic trend_fall;
    logic [1:0] measured_event;
    logic [3:0] time_event;
    logic alarm_one;
    logic program_mode;
    logic reset_mode;
    logic hold_mode;
    logic local_mode;
    logic manual_mode;
    logic second_manual;
    logic remote_setpoint;
    logic running;
    logic second_loop_shown;
    logic error_active;
  } fpklc_core_t;

  typedef struct packed {
    logic trend_up_lamp;
    logic trend_flat_lamp;
    logic trend_down_lamp;
    logic measured_event_one_lamp;
    logic measured_event_two_lamp;
    logic [3:0] timed_event_lamps;
    logic alarm_one_lamp;
    logic program_mode_lamp;
    logic reset_mode_lamp;
    logic hold_mode_lamp;
    logic station_mode_lamp;
    logic hand_operation_lamp;
    logic second_hand_lamp;
    logic remote_setpoint_lamp;
    logic second_input_lamp;
    logic show_error_code;
  } fpklc_lamp_t;

  typedef struct packed {
    logic run_cmd;
    logic stop_cmd;
    logic value_inc;
    logic value_dec;
    logic commit_value;
    logic next_param;
    logic menu_next;
    logic menu_prev;
  } fpklc_cmd_t;
endpackage

// ---- logic/fpklc_front_panel.sv ----
// front panel key decoding, view control, lamp drive and register slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - run key held over 2 s in operating view issues run command
// - reset key held over 2 s in operating view issues stop command
// - confirm key held over 3 s toggles operating view and top menu
// - short confirm press commits an edited value or advances parameter
// - view-cycle key in operating view steps to next operating view
// - view-cycle key in other views goes back exactly one level
// - at most three view-cycle presses return to operating view
// - down decrements, up increments value on value-setting views
// - held up/down keys repeat at a rate that rises over time
// - up/down move between menu entries on top menu or submenu
// - pattern key changes pattern only when stopped in operating view
// - three trend lamps one-hot: rising, constant, falling
// - measured-event lamps follow measured events one and two
// - four time-event lamps follow time events one to four
// - alarm lamp lit exactly while instrument alarm one active
// - program, reset and hold lamps follow controller state
// - station lamp follows local mode, hand lamp follows manual mode
// - second-hand and remote-setpoint lamps unlit in switched-input setup
// - second-input lamp lit only when second loop shown, never if switched
// - mode key opens the mode selection view
// - error replaces measured value with an error code
// - contact inputs act only when enable parameter equals 2
// - contact change accepted after three stable sampling periods
module fpklc_front_panel
  import fpklc_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES,
  parameter int SAMPLE_PERIOD_MS = SAMPLE_MS,
  parameter int PATTERNS = NUM_PATTERNS,
  parameter int VIEWS = OPER_VIEWS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // panel pins
  input wire logic [NUM_KEYS-1:0] key_pressed,
  input wire logic [NUM_CONTACTS-1:0] contact_in,
  // controller core
  input wire fpklc_core_t core,
  output fpklc_cmd_t cmd,
  output fpklc_lamp_t lamps,
  output fpklc_view_t view,
  output logic [4:0] pattern_number,
  output logic [3:0] menu_index
);
  initial begin
    if (TICK_CYCLES < 1 || SAMPLE_PERIOD_MS < 1 || PATTERNS < 1 || PATTERNS > 31 ||
        VIEWS < 1 || VIEWS > 8) begin
      $error("fpklc_front_panel: unsupported parameter value");
    end
  end

  // millisecond tick
  logic [31:0] tick_cnt;
  logic ms_tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // per key synchroniser, debounce and hold timer
  logic [NUM_KEYS-1:0] key_level;
  logic [NUM_KEYS-1:0] key_prev;
  logic [NUM_KEYS-1:0] long_done;
  logic [NUM_KEYS-1:0] long_fire;
  logic [HOLD_W-1:0] key_hold [NUM_KEYS];
  localparam logic [HOLD_W-1:0] HOLD_MAX = '1;

  function automatic logic [HOLD_W-1:0] long_limit(input int k);
    if (k == K_RUN || k == K_RESET) begin
      return HOLD_W'(RUN_HOLD_MS + 1);
    end else if (k == K_CONFIRM) begin
      return HOLD_W'(MENU_HOLD_MS + 1);
    end
    return HOLD_MAX;
  endfunction

  for (genvar g = 0; g < NUM_KEYS; g++) begin : g_key
    logic sync_a;
    logic sync_b;
    logic stable;
    logic [4:0] deb;
    logic [HOLD_W-1:0] hold;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync_a <= 1'b0;
        sync_b <= 1'b0;
        stable <= 1'b0;
        deb <= 5'h0;
        hold <= '0;
        long_done[g] <= 1'b0;
      end else begin
        sync_a <= key_pressed[g];
        sync_b <= sync_a;
        if (sync_b == stable) begin
          deb <= 5'h0;
        end else if (ms_tick) begin
          deb <= (deb == 5'(DEBOUNCE_MS - 1)) ? 5'h0 : deb + 5'h1;
          if (deb == 5'(DEBOUNCE_MS - 1)) begin
            stable <= sync_b;
          end
        end
        if (!stable) begin
          hold <= '0;
        end else if (ms_tick && hold != HOLD_MAX) begin
          hold <= hold + 1'b1;
        end
        if (long_fire[g]) begin
          long_done[g] <= 1'b1;
        end else if (!stable) begin
          long_done[g] <= 1'b0;
        end
      end
    end
    assign key_level[g] = stable;
    assign key_hold[g] = hold;
    assign long_fire[g] = stable && hold >= long_limit(g) && !long_done[g];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_prev <= '0;
    end else begin
      key_prev <= key_level;
    end
  end

  wire [NUM_KEYS-1:0] key_press = key_level & ~key_prev;
  wire [NUM_KEYS-1:0] key_short = ~key_level & key_prev & ~long_done;

  // up/down auto repeat
  logic [HOLD_W-1:0] rep_cnt;
  wire rep_key = key_level[K_UP] | key_level[K_DOWN];
  wire [HOLD_W-1:0] rep_hold = key_level[K_UP] ? key_hold[K_UP] : key_hold[K_DOWN];
  wire [HOLD_W-1:0] rep_gap = (rep_hold < HOLD_W'(REPEAT_MID_AT_MS)) ? HOLD_W'(REPEAT_SLOW_MS) :
    (rep_hold < HOLD_W'(REPEAT_FAST_AT_MS)) ? HOLD_W'(REPEAT_MID_MS) : HOLD_W'(REPEAT_FAST_MS);
  wire rep_fire = rep_key && ms_tick && rep_hold >= HOLD_W'(REPEAT_DELAY_MS) &&
    rep_cnt + 1'b1 >= rep_gap;
  always_ff @(posedge aclk) begin
    if (!aresetn || !rep_key || rep_fire) begin
      rep_cnt <= '0;
    end else if (ms_tick && rep_hold >= HOLD_W'(REPEAT_DELAY_MS)) begin
      rep_cnt <= rep_cnt + 1'b1;
    end
  end
  wire step_up = key_press[K_UP] | (rep_fire & key_level[K_UP]);
  wire step_down = key_press[K_DOWN] | (rep_fire & ~key_level[K_UP]);

  // contact inputs
  logic [NUM_CONTACTS-1:0] ct_a;
  logic [NUM_CONTACTS-1:0] ct_b;
  logic [NUM_CONTACTS-1:0] ct_cand;
  logic [NUM_CONTACTS-1:0] ct_state;
  logic [NUM_CONTACTS-1:0] ct_prev;
  logic [1:0] ct_stable_cnt;
  logic [15:0] sample_cnt;
  wire sample_tick = ms_tick && sample_cnt == 16'(SAMPLE_PERIOD_MS - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_a <= '0;
      ct_b <= '0;
      ct_cand <= '0;
      ct_state <= '0;
      ct_prev <= '0;
      ct_stable_cnt <= 2'h0;
      sample_cnt <= 16'h0;
    end else begin
      ct_a <= contact_in;
      ct_b <= ct_a;
      ct_prev <= ct_state;
      if (ms_tick) begin
        sample_cnt <= sample_tick ? 16'h0 : sample_cnt + 16'h1;
      end
      if (sample_tick) begin
        ct_cand <= ct_b;
        if (ct_b != ct_cand) begin
          ct_stable_cnt <= 2'h1;
        end else if (ct_stable_cnt != 2'(CONTACT_STABLE_SAMPLES)) begin
          ct_stable_cnt <= ct_stable_cnt + 2'h1;
        end else begin
          ct_state <= ct_cand;
        end
      end
    end
  end

  // control and event registers
  logic [31:0] ctrl;
  logic [NUM_EVENTS-1:0] events;
  wire contacts_on = ctrl[CTRL_ENABLE_LSB +: 8] == CONTACT_ENABLE_CODE;
  wire switched_cfg = ctrl[CTRL_SWITCHED_BIT];
  wire ct_run = contacts_on & ct_state[C_RUN] & ~ct_prev[C_RUN];
  wire ct_reset = contacts_on & ct_state[C_RESET] & ~ct_prev[C_RESET];

  // view machine
  fpklc_view_t next_view;
  logic [2:0] oper_idx;
  logic [2:0] next_oper_idx;
  logic [3:0] next_menu_index;
  logic [4:0] next_pattern;
  logic edited;
  logic next_edited;
  fpklc_cmd_t next_cmd;
  wire in_oper = view == VIEW_OPER;
  wire menu_toggle = long_fire[K_CONFIRM];
  always_comb begin
    next_view = view;
    next_oper_idx = oper_idx;
    next_menu_index = menu_index;
    next_pattern = pattern_number;
    next_edited = edited;
    next_cmd = '0;
    next_cmd.run_cmd = (in_oper & long_fire[K_RUN]) | ct_run;
    next_cmd.stop_cmd = (in_oper & long_fire[K_RESET]) | ct_reset;
    if (menu_toggle) begin
      next_view = in_oper ? VIEW_MENU_TOP : VIEW_OPER;
      next_menu_index = 4'h0;
      next_edited = 1'b0;
    end else if (key_press[K_MODE]) begin
      next_view = VIEW_MODE_SEL;
    end else if (key_press[K_VIEW]) begin
      unique case (view)
        VIEW_OPER: next_oper_idx = (oper_idx == 3'(VIEWS - 1)) ? 3'h0 : oper_idx + 3'h1;
        VIEW_MENU_TOP: next_view = VIEW_OPER;
        VIEW_MENU_SUB: next_view = VIEW_MENU_TOP;
        VIEW_PARAM: next_view = VIEW_MENU_SUB;
        VIEW_MODE_SEL: next_view = VIEW_OPER;
        default: next_view = VIEW_OPER;
      endcase
      next_edited = 1'b0;
    end else if (key_short[K_CONFIRM]) begin
      unique case (view)
        VIEW_MENU_TOP: next_view = VIEW_MENU_SUB;
        VIEW_MENU_SUB: next_view = VIEW_PARAM;
        VIEW_PARAM: begin
          next_cmd.commit_value = edited;
          next_cmd.next_param = ~edited;
          next_edited = 1'b0;
        end
        VIEW_OPER, VIEW_MODE_SEL: next_cmd.commit_value = 1'b1;
        default: next_view = VIEW_OPER;
      endcase
    end else if (step_up || step_down) begin
      if (view == VIEW_MENU_TOP || view == VIEW_MENU_SUB) begin
        next_cmd.menu_next = step_up;
        next_cmd.menu_prev = step_down;
        next_menu_index = step_up ? menu_index + 4'h1 : menu_index - 4'h1;
        if (step_up && menu_index == MENU_ENTRIES) begin
          next_menu_index = 4'h0;
        end
      end else begin
        next_cmd.value_inc = step_up;
        next_cmd.value_dec = step_down;
        next_edited = 1'b1;
      end
    end else if (key_press[K_PATTERN] && in_oper && !core.running) begin
      next_pattern = (pattern_number == 5'(PATTERNS)) ? 5'h1 : pattern_number + 5'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      view <= VIEW_OPER;
      oper_idx <= 3'h0;
      menu_index <= 4'h0;
      pattern_number <= 5'h1;
      edited <= 1'b0;
      cmd <= '0;
    end else begin
      view <= next_view;
      oper_idx <= next_oper_idx;
      menu_index <= next_menu_index;
      pattern_number <= next_pattern;
      edited <= next_edited;
      cmd <= next_cmd;
    end
  end

  // lamps
  fpklc_lamp_t next_lamps;
  always_comb begin
    next_lamps = '0;
    next_lamps.trend_up_lamp = core.trend_rise;
    next_lamps.trend_flat_lamp = core.trend_const & ~core.trend_rise;
    next_lamps.trend_down_lamp = core.trend_fall & ~core.trend_rise & ~core.trend_const;
    next_lamps.measured_event_one_lamp = core.measured_event[0];
    next_lamps.measured_event_two_lamp = core.measured_event[1];
    next_lamps.timed_event_lamps = core.time_event;
    next_lamps.alarm_one_lamp = core.alarm_one;
    next_lamps.program_mode_lamp = core.program_mode;
    next_lamps.reset_mode_lamp = core.reset_mode;
    next_lamps.hold_mode_lamp = core.hold_mode;
    next_lamps.station_mode_lamp = core.local_mode;
    next_lamps.hand_operation_lamp = core.manual_mode;
    next_lamps.second_hand_lamp = core.second_manual & ~switched_cfg;
    next_lamps.remote_setpoint_lamp = core.remote_setpoint & ~switched_cfg;
    next_lamps.second_input_lamp = core.second_loop_shown & ~switched_cfg;
    next_lamps.show_error_code = core.error_active;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamps <= '0;
    end else begin
      lamps <= next_lamps;
    end
  end

  // axi4-lite slave
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl = do_write && wr_addr == REG_CTRL;
  wire wr_event = do_write && wr_addr == REG_EVENT && wr_strb[0];
  wire wr_known = wr_addr == REG_CTRL || wr_addr == REG_STATUS || wr_addr == REG_EVENT;
  wire [NUM_EVENTS-1:0] ev_set = {ct_state != ct_prev, next_pattern != pattern_number,
    next_cmd.commit_value, menu_toggle, next_cmd.stop_cmd, next_cmd.run_cmd};
  wire [NUM_EVENTS-1:0] ev_clr = wr_event ? wr_data[NUM_EVENTS-1:0] : '0;
  wire [31:0] status_word = {4'h0, menu_index, 1'b0, ct_state, 3'h0, pattern_number,
    1'b0, oper_idx, 1'b0, view};
  wire [31:0] rd_word = (s_axi_araddr == REG_CTRL) ? ctrl :
    (s_axi_araddr == REG_STATUS) ? status_word :
    (s_axi_araddr == REG_EVENT) ? {26'h0, events} : 32'h0;
  wire rd_known = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_STATUS ||
    s_axi_araddr == REG_EVENT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      events <= '0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
      for (int b = 0; b < 4; b++) begin
        if (wr_ctrl && wr_strb[b]) begin
          ctrl[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        wr_addr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ---- verification/fpklc_front_panel_asserts.sv ----
// port assertions for the front panel key and lamp control
`timescale 1ns/1ps
module fpklc_front_panel_asserts
  import fpklc_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // panel side
  input wire logic [NUM_KEYS-1:0] key_pressed,
  input wire logic [NUM_CONTACTS-1:0] contact_in,
  // core side
  input wire fpklc_core_t core,
  input wire fpklc_cmd_t cmd,
  input wire fpklc_lamp_t lamps,
  input wire fpklc_view_t view,
  input wire logic [4:0] pattern_number
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] run_held;
  always_ff @(posedge aclk) begin
    run_held <= key_pressed[K_RUN] ? run_held + 32'h1 : 32'h0;
  end
  chk_alarm_lamp: assert property (
    $past(aresetn, 2) |-> lamps.alarm_one_lamp == $past(core.alarm_one))
    else $error("alarm lamp wrong");
  chk_time_lamps: assert property (
    $past(aresetn, 2) |-> lamps.timed_event_lamps == $past(core.time_event))
    else $error("time event lamps wrong");
  chk_measured_lamps: assert property (
    $past(aresetn, 2) |-> {lamps.measured_event_two_lamp, lamps.measured_event_one_lamp}
      == $past(core.measured_event))
    else $error("measured event lamps wrong");
  chk_trend_onehot: assert property (
    $past(aresetn, 2) && $past(core.trend_rise | core.trend_const | core.trend_fall)
    |-> $onehot({lamps.trend_up_lamp, lamps.trend_flat_lamp, lamps.trend_down_lamp})
      && lamps.trend_up_lamp == $past(core.trend_rise))
    else $error("trend lamps wrong");
  chk_state_lamps: assert property (
    $past(aresetn, 2) |-> {lamps.program_mode_lamp, lamps.reset_mode_lamp, lamps.hold_mode_lamp}
      == $past({core.program_mode, core.reset_mode, core.hold_mode}))
    else $error("status lamps wrong");
  chk_local_hand: assert property (
    $past(aresetn, 2) |-> {lamps.station_mode_lamp, lamps.hand_operation_lamp}
      == $past({core.local_mode, core.manual_mode}))
    else $error("local or hand lamp wrong");
  chk_run_hold: assert property (
    cmd.run_cmd |-> run_held > 2000 * TICK_CYCLES || contact_in[C_RUN])
    else $error("run command without long hold");
  chk_run_once: assert property (
    cmd.run_cmd |=> !cmd.run_cmd ##1 !cmd.run_cmd)
    else $error("run command repeated");
  chk_stop_view: assert property (
    cmd.stop_cmd && !contact_in[C_RESET] |-> $past(view) == VIEW_OPER)
    else $error("stop command outside operating view");
  chk_pattern_gate: assert property (
    $past(aresetn) && $changed(pattern_number)
    |-> $past(view) == VIEW_OPER && !$past(core.running))
    else $error("pattern changed while refused");
endmodule
bind fpklc_front_panel fpklc_front_panel_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .key_pressed(key_pressed), .contact_in(contact_in),
  .core(core), .cmd(cmd), .lamps(lamps), .view(view), .pattern_number(pattern_number));

// ---- verification/fpklc_operator.sv ----
// operator model pressing keys and closing contacts
`timescale 1ns/1ps
module fpklc_operator
  import fpklc_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  // clock
  input wire logic aclk,
  // panel pins
  output logic [NUM_KEYS-1:0] key_pressed,
  output logic [NUM_CONTACTS-1:0] contact_in
);
  initial begin
    key_pressed = '0;
    contact_in = '0;
  end
  // hold a key or contact for ms, then release and rest
  task automatic act(input bit is_contact, input int k, input int ms);
    @(posedge aclk);
    if (is_contact) contact_in[k] <= 1'b1;
    else key_pressed[k] <= 1'b1;
    repeat (ms * TICK_CYCLES) @(posedge aclk);
    if (is_contact) contact_in[k] <= 1'b0;
    else key_pressed[k] <= 1'b0;
    repeat (40 * TICK_CYCLES) @(posedge aclk);
  endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the front panel key and lamp control
`timescale 1ns/1ps
module tb;
  import fpklc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  fpklc_core_t core;
  fpklc_cmd_t cmd;
  fpklc_lamp_t lamps;
  fpklc_view_t view;
  logic [4:0] pattern_number;
  logic [3:0] menu_index;
  logic [NUM_KEYS-1:0] keys;
  logic [NUM_CONTACTS-1:0] contacts;
  logic [19:0] pats [3] = '{20'h8D25B, 20'h32DA0, 20'h40000};
  int mismatches = 0;
  int total_checks = 0;
  int pulses [8] = '{default: 0};
  always #4 aclk = ~aclk;
  fpklc_operator #(.TICK_CYCLES(5)) op (.aclk(aclk), .key_pressed(keys), .contact_in(contacts));
  fpklc_front_panel #(.TICK_CYCLES(5), .SAMPLE_PERIOD_MS(1)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_pressed(keys), .contact_in(contacts), .core(core), .cmd(cmd), .lamps(lamps),
    .view(view), .pattern_number(pattern_number), .menu_index(menu_index));
  // count one-cycle command pulses, bit 7 run down to bit 0 menu_prev
  always @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (cmd[i] === 1'b1) pulses[i]++;
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit done;
    done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bit done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  function automatic fpklc_lamp_t lamp_exp(input fpklc_core_t c, input logic sw);
    lamp_exp = {c.trend_rise, c.trend_const, c.trend_fall, c.measured_event[0],
      c.measured_event[1], c.time_event, c.alarm_one, c.program_mode, c.reset_mode,
      c.hold_mode, c.local_mode, c.manual_mode, c.second_manual & ~sw,
      c.remote_setpoint & ~sw, c.second_loop_shown & ~sw, c.error_active};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (70000) @(posedge aclk);
    mismatches++;
    finish_test();
  end
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    core = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("view", VIEW_OPER, view);
    check("pattern", 32'h1, pattern_number);
    check("menu", 32'h0, menu_index);
    wr(REG_CTRL, 32'h0000_0102, RESP_OKAY);
    rd(REG_CTRL);
    check("ctrl", 32'h0000_0102, d);
    wr(8'h0C, 32'h0000_00FF, RESP_SLVERR);
    rd(8'h0C);
    check("unmapped", 32'h0, d);
    check("rresp", RESP_SLVERR, r);
    wr(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    for (int s = 1; s >= 0; s--) begin
      wr(REG_CTRL, {23'h0, s[0], 8'h02}, RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
        core <= pats[i];
        repeat (3) @(posedge aclk);
        check("lamps", lamp_exp(pats[i], s[0]), lamps);
      end
    end
    core <= '0;
    op.act(0, K_VIEW, 30);
    rd(REG_STATUS);
    check("oper view", 32'h1, (d >> 4) & 32'h7);
    op.act(0, K_PATTERN, 30);
    check("pattern", 32'h2, pattern_number);
    core.running <= 1'b1;
    op.act(0, K_PATTERN, 30);
    check("pattern run", 32'h2, pattern_number);
    core.running <= 1'b0;
    op.act(0, K_UP, 750);
    check("inc held", 32'h2, pulses[5]);
    op.act(0, K_DOWN, 30);
    check("dec", 32'h1, pulses[4]);
    op.act(0, K_RUN, 2100);
    check("run", 32'h1, pulses[7]);
    op.act(0, K_RESET, 2100);
    check("stop", 32'h1, pulses[6]);
    op.act(1, C_RUN, 1);
    check("run glitch", 32'h1, pulses[7]);
    op.act(1, C_RUN, 10);
    check("run contact", 32'h2, pulses[7]);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    op.act(1, C_RESET, 10);
    check("stop contact", 32'h1, pulses[6]);
    op.act(0, K_CONFIRM, 3100);
    check("menu view", VIEW_MENU_TOP, view);
    check("no short", 32'h0, pulses[3]);
    op.act(0, K_UP, 30);
    check("menu up", 32'h1, menu_index);
    check("menu next", 32'h1, pulses[1]);
    check("no inc", 32'h2, pulses[5]);
    op.act(0, K_DOWN, 30);
    check("menu down", 32'h0, menu_index);
    check("menu prev", 32'h1, pulses[0]);
    op.act(0, K_CONFIRM, 30);
    check("submenu", VIEW_MENU_SUB, view);
    op.act(0, K_CONFIRM, 30);
    check("param view", VIEW_PARAM, view);
    op.act(0, K_CONFIRM, 30);
    check("next param", 32'h1, pulses[2]);
    op.act(0, K_UP, 30);
    check("param inc", 32'h3, pulses[5]);
    op.act(0, K_CONFIRM, 30);
    check("param commit", 32'h1, pulses[3]);
    op.act(0, K_VIEW, 30);
    check("back sub", VIEW_MENU_SUB, view);
    op.act(0, K_VIEW, 30);
    check("back top", VIEW_MENU_TOP, view);
    op.act(0, K_VIEW, 30);
    check("back", VIEW_OPER, view);
    op.act(0, K_MODE, 30);
    check("mode view", VIEW_MODE_SEL, view);
    op.act(0, K_VIEW, 30);
    check("back", VIEW_OPER, view);
    op.act(0, K_CONFIRM, 30);
    check("commit", 32'h2, pulses[3]);
    finish_test();
  end
endmodule
